//--- design/cfi_cfg.svh
// Offsets, field positions and reset values for the CAN FIFO 1 and interrupt enable block.
// Assumes a byte-addressed AXI4-Lite slave with 8 address bits.
`ifndef CFI_CFG_SVH
`define CFI_CFG_SVH

`define CFI_OFF_RF1 8'h10
`define CFI_OFF_INTEN 8'h14
`define CFI_OFF_FLAG 8'h18
`define CFI_OFF_IST 8'h20
`define CFI_OFF_ICLR 8'h24
`define CFI_OFF_IEN 8'h28

`define CFI_RF1_RLS 5
`define CFI_RF1_OVF 4
`define CFI_RF1_FULL 3

`define CFI_IE_EDZ 17
`define CFI_IE_QDZ 16
`define CFI_IE_EO 15
`define CFI_IE_ETR 11
`define CFI_IE_BO 10
`define CFI_IE_EP 9
`define CFI_IE_OVF1 6
`define CFI_IE_FULL1 5
`define CFI_INTEN_MASK 32'h00038E60
`define CFI_INTEN_RST 32'h00000000

`define CFI_FL_EO 0
`define CFI_FL_EDZ 1
`define CFI_FL_QDZ 2

`define CFI_CNT_FULL 2'h3
`define CFI_CNT_LAST 2'h2

`define CFI_NEVT 4
`define CFI_RESP_OKAY 2'h0
`define CFI_RESP_SLVERR 2'h2

`endif

//--- design/cfi_pkg.sv
// Types shared by the CAN FIFO 1 and interrupt enable block.
// Assumes the cfg header supplies all numeric constants.
package cfi_pkg;

  typedef struct packed {
    logic msg_accept;
    logic doze_entry;
    logic doze_exit;
    logic error_type_wr;
    logic [2:0] error_type_code;
    logic bus_off_flag;
    logic error_passive_flag;
  } cfi_hw_evt_s;

  typedef struct packed {
    logic doze_entry;
    logic doze_exit;
    logic error;
    logic fifo1_overflow;
    logic fifo1_full;
  } cfi_irq_s;

endpackage

//--- design/cfi_top.sv
// FIFO 1 status/control, interrupt enables and event interrupt logic of a CAN controller.
// Assumes receive engine, filters and protocol engine share mclk_in and drive hw_evt_in.
//
// Notes on behaviour
// - Writing one to release drops oldest message; hardware clears the bit afterwards.
// - Release request while FIFO 1 is empty is ignored entirely.
// - Overflow flag sets on accepted message while full; cleared by writing one.
// - Full flag sets when three messages pending; cleared by writing one.
// - Read-only two-bit pending count rises per accepted message while not full.
// - Pending count falls by one for each performed release.
// - Doze-entry interrupt only while its enable and flag are set; enable resets zero.
// - Doze-exit interrupt only while its enable and flag are both set.
// - Error interrupt only while error enable and error summary flag are set.
// - Nonzero error type code sets error summary only when its enable is set.
// - Bus-off raising sets error summary only when bus-off enable is set.
// - Error-passive raising sets error summary only when its enable is set.
// - Overflow and full interrupts each follow their flag under their own enable.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cfi_cfg.svh"

module cfi_top
  import cfi_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Receive engine side
  input wire cfi_hw_evt_s hw_evt_in,
  output logic fifo1_release_out,
  // Interrupts
  output cfi_irq_s irq_src_out,
  output logic irq_out
);

  logic aw_held, w_held, wr_do, wr_rf1, wr_inten, wr_flag, wr_iclr, wr_ien, wr_hit;
  logic [7:0] aw_addr;
  logic [31:0] w_data, wm, w1;
  logic [3:0] w_strb;
  logic fifo1_release_req, fifo1_overflow_flag, fifo1_full_flag;
  logic cnt_inc, rel_set, ovf_set, full_set;
  logic [1:0] fifo1_pending_count, next_count;
  logic [31:0] interrupt_enable;
  logic error_summary_flag, doze_entry_flag, doze_exit_flag;
  logic [2:0] error_type_code;
  logic bus_off_q, err_pas_q, eo_set;
  logic [`CFI_NEVT-1:0] evt, irq_status, irq_en;
  logic [31:0] rd_mux;
  logic rd_hit, ar_fire;

  // Write channel: address and data taken in either order, answer once both held
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign wr_do = aw_held && w_held && !s_axi_bvalid_out;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end
    else if (wr_do)
    begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end
    else if (wr_do)
    begin
      w_held <= 1'b0;
    end
  end

  assign wm = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign w1 = w_data & wm;
  assign wr_rf1 = wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_RF1);
  assign wr_inten = wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_INTEN);
  assign wr_flag = wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_FLAG);
  assign wr_iclr = wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_ICLR);
  assign wr_ien = wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_IEN);
  assign wr_hit = wr_rf1 || wr_inten || wr_flag || wr_iclr || wr_ien
    || (wr_do && ({aw_addr[7:2], 2'b00} == `CFI_OFF_IST));

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `CFI_RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= wr_hit ? `CFI_RESP_OKAY : `CFI_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  // Release: request held one cycle, then performed; the pulse is the drop strobe
  assign rel_set = wr_rf1 && w1[`CFI_RF1_RLS] && (fifo1_pending_count != 2'h0);
  assign fifo1_release_out = fifo1_release_req;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      fifo1_release_req <= 1'b0;
    else if (fifo1_release_req)
      fifo1_release_req <= 1'b0;
    else
      fifo1_release_req <= rel_set;
  end

  // Pending count; an accept seen while full is counted as overflow instead
  assign cnt_inc = hw_evt_in.msg_accept && (fifo1_pending_count != `CFI_CNT_FULL);
  assign next_count = 2'(fifo1_pending_count + {1'b0, cnt_inc} - {1'b0, fifo1_release_req});
  assign ovf_set = hw_evt_in.msg_accept && (fifo1_pending_count == `CFI_CNT_FULL);
  assign full_set = (next_count == `CFI_CNT_FULL) && (fifo1_pending_count == `CFI_CNT_LAST);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      fifo1_pending_count <= 2'h0;
    else
      fifo1_pending_count <= next_count;
  end

  // Set wins over a same-cycle clear so no event is lost
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      fifo1_overflow_flag <= 1'b0;
    else if (ovf_set)
      fifo1_overflow_flag <= 1'b1;
    else if (wr_rf1 && w1[`CFI_RF1_OVF])
      fifo1_overflow_flag <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      fifo1_full_flag <= 1'b0;
    else if (full_set)
      fifo1_full_flag <= 1'b1;
    else if (wr_rf1 && w1[`CFI_RF1_FULL])
      fifo1_full_flag <= 1'b0;
  end

  // Interrupt enables; unimplemented bits stay zero
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      interrupt_enable <= `CFI_INTEN_RST;
    else if (wr_inten)
      interrupt_enable <= (interrupt_enable & ~wm) | (w1 & `CFI_INTEN_MASK);
  end

  // Error summary sources; bus-off and passive act on their rising edge only
  assign eo_set =
    (hw_evt_in.error_type_wr && (hw_evt_in.error_type_code != 3'h0)
      && interrupt_enable[`CFI_IE_ETR])
    || (hw_evt_in.bus_off_flag && !bus_off_q && interrupt_enable[`CFI_IE_BO])
    || (hw_evt_in.error_passive_flag && !err_pas_q && interrupt_enable[`CFI_IE_EP]);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      bus_off_q <= 1'b0;
      err_pas_q <= 1'b0;
    end
    else
    begin
      bus_off_q <= hw_evt_in.bus_off_flag;
      err_pas_q <= hw_evt_in.error_passive_flag;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      error_type_code <= 3'h0;
    else if (hw_evt_in.error_type_wr)
      error_type_code <= hw_evt_in.error_type_code;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      error_summary_flag <= 1'b0;
    else if (eo_set)
      error_summary_flag <= 1'b1;
    else if (wr_flag && w1[`CFI_FL_EO])
      error_summary_flag <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      doze_entry_flag <= 1'b0;
    else if (hw_evt_in.doze_entry)
      doze_entry_flag <= 1'b1;
    else if (wr_flag && w1[`CFI_FL_EDZ])
      doze_entry_flag <= 1'b0;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      doze_exit_flag <= 1'b0;
    else if (hw_evt_in.doze_exit)
      doze_exit_flag <= 1'b1;
    else if (wr_flag && w1[`CFI_FL_QDZ])
      doze_exit_flag <= 1'b0;
  end

  // Per-source lines are plain ANDs of two flops, so they follow the flag with no lag
  assign irq_src_out.doze_entry = interrupt_enable[`CFI_IE_EDZ] && doze_entry_flag;
  assign irq_src_out.doze_exit = interrupt_enable[`CFI_IE_QDZ] && doze_exit_flag;
  assign irq_src_out.error = interrupt_enable[`CFI_IE_EO] && error_summary_flag;
  assign irq_src_out.fifo1_overflow = interrupt_enable[`CFI_IE_OVF1] && fifo1_overflow_flag;
  assign irq_src_out.fifo1_full = interrupt_enable[`CFI_IE_FULL1] && fifo1_full_flag;

  // Sticky event status, write-one clear, enable; set wins over clear
  assign evt = {full_set, ovf_set, fifo1_release_req, cnt_inc};
  generate
    for (genvar gi = 0; gi < `CFI_NEVT; gi = gi + 1)
    begin : g_ist
      always_ff @(posedge mclk_in)
      begin
        if (srst_in)
          irq_status[gi] <= 1'b0;
        else if (evt[gi])
          irq_status[gi] <= 1'b1;
        else if (wr_iclr && w1[gi])
          irq_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      irq_en <= '0;
    else if (wr_ien && w_strb[0])
      irq_en <= w_data[`CFI_NEVT-1:0];
  end

  assign irq_out = |(irq_status & irq_en);

  // Read channel: one read at a time, data one cycle after the address is taken
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;

  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'b00})
      `CFI_OFF_RF1:
        rd_mux = {26'h0, fifo1_release_req, fifo1_overflow_flag, fifo1_full_flag,
          1'b0, fifo1_pending_count};
      `CFI_OFF_INTEN:
        rd_mux = interrupt_enable;
      `CFI_OFF_FLAG:
        rd_mux = {25'h0, error_type_code, 1'b0, doze_exit_flag, doze_entry_flag, error_summary_flag};
      `CFI_OFF_IST:
        rd_mux = {28'h0, irq_status};
      `CFI_OFF_ICLR:
        rd_mux = 32'h00000000;
      `CFI_OFF_IEN:
        rd_mux = {28'h0, irq_en};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `CFI_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_mux;
      s_axi_rresp_out <= rd_hit ? `CFI_RESP_OKAY : `CFI_RESP_SLVERR;
    end
    else if (s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // cfi_top

//--- bench/cfi_top_assertions.sv
// Checker for the FIFO 1 and interrupt enable block.
// Assumes it is bound onto cfi_top ports.
`timescale 1ns/1ps
module cfi_top_assertions
  import cfi_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Bus handshake
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Events and interrupts
  input wire cfi_hw_evt_s hw_evt_in,
  input wire logic fifo1_release_out,
  input wire cfi_irq_s irq_src_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  a_rel_one_pulse: assert property (fifo1_release_out |=> !fifo1_release_out)
    else $error("release pulse too long");
  a_rel_from_write: assert property (fifo1_release_out |-> $rose(s_axi_bvalid_out))
    else $error("release without a write");
  a_doze_in_cause: assert property ($rose(irq_src_out.doze_entry) |->
    $past(hw_evt_in.doze_entry) || $rose(s_axi_bvalid_out))
    else $error("doze entry irq without cause");
  a_doze_out_cause: assert property ($rose(irq_src_out.doze_exit) |->
    $past(hw_evt_in.doze_exit) || $rose(s_axi_bvalid_out))
    else $error("doze exit irq without cause");
  a_err_cause: assert property ($rose(irq_src_out.error) |-> $rose(s_axi_bvalid_out) ||
    $past(hw_evt_in.error_type_wr && hw_evt_in.error_type_code != 3'h0) ||
    $past(hw_evt_in.bus_off_flag) || $past(hw_evt_in.error_passive_flag))
    else $error("error irq without cause");
  a_ovf_cause: assert property ($rose(irq_src_out.fifo1_overflow) |->
    $past(hw_evt_in.msg_accept) || $rose(s_axi_bvalid_out))
    else $error("overflow irq without cause");
  a_full_clear: assert property ($fell(irq_src_out.fifo1_full) |-> $rose(s_axi_bvalid_out))
    else $error("full irq fell without write");
  a_rd_done: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read answer repeated");
endmodule // cfi_top_assertions

bind cfi_top cfi_top_assertions cfi_top_assertions_inst (.mclk_in(mclk_in), .srst_in(srst_in),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .hw_evt_in(hw_evt_in),
  .fifo1_release_out(fifo1_release_out), .irq_src_out(irq_src_out));

//--- bench/cfi_top_test.sv
// Self-checking bench for the FIFO 1 and interrupt enable block.
// Assumes the design files and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module cfi_top_test;
  int miscompares = 0;
  int num_checks = 0;
  int nrel = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [8:0] hw = 9'h000;
  logic [4:0] irq;
  logic [1:0] rresp, bresp, bres;
  logic [3:0] ws = 4'hF;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic awr, wrdy, bv, arr, rv, rel, iq;

  cfi_top cfi_top_inst (.mclk_in(clk), .srst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .hw_evt_in(hw),
    .fifo1_release_out(rel), .irq_src_out(irq), .irq_out(iq));

  initial
  begin
    forever #25 clk = ~clk;
  end

  always @(posedge clk) if (rel) nrel++;

  task summarize;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task hang;
    miscompares++;
    $display("unexpected t=%0t bus wait ran out", $time);
    summarize();
  endtask

  // Done flag is blocking so the loop test never sees a stale handshake bit
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic bdone;
    bdone = 1'b0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 40 && !bdone; n++)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv)
      begin
        br <= 1'b0;
        bres = bresp;
        bdone = 1'b1;
      end
    end
    if (!bdone) hang();
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    logic rdone;
    rdone = 1'b0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 40 && !rdone; n++)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv)
      begin
        rr <= 1'b0;
        rdone = 1'b1;
        `CHK(rdat, e)
        `CHK(rresp, r)
      end
    end
    if (!rdone) hang();
    @(posedge clk);
  endtask

  // Level inputs keep their value after a pulse
  task automatic pe(input logic [8:0] e);
    hw <= e;
    @(posedge clk);
    hw <= e & 9'h003;
    @(posedge clk);
  endtask

  task t_regs;
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    wr(8'h14, 32'hFFFFFFFF);
    `CHK(bres, 2'h0)
    rd(8'h14, 32'h00038E60, 2'h0);
    ws <= 4'h2;
    wr(8'h14, 32'h0);
    ws <= 4'hF;
    rd(8'h14, 32'h00030060, 2'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    `CHK(bres, 2'h2)
    rd(8'h3C, 32'h0, 2'h2);
    $display("t_regs done");
  endtask

  task t_fifo;
    int r0;
    wr(8'h14, 32'h00000060);
    repeat (3) pe(9'h100);
    rd(8'h10, 32'h0000000B, 2'h0);
    pe(9'h100);
    rd(8'h10, 32'h0000001B, 2'h0);
    `CHK(irq, 5'h03)
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h0000001B, 2'h0);
    wr(8'h10, 32'h00000018);
    rd(8'h10, 32'h00000003, 2'h0);
    r0 = nrel;
    repeat (4) wr(8'h10, 32'h00000020);
    rd(8'h10, 32'h0, 2'h0);
    `CHK(nrel - r0, 3)
    $display("t_fifo done");
  endtask

  task t_evt;
    wr(8'h24, 32'h0000000F);
    wr(8'h28, 32'h00000001);
    pe(9'h100);
    `CHK(iq, 1'b1)
    rd(8'h20, 32'h00000001, 2'h0);
    wr(8'h28, 32'h0);
    `CHK(iq, 1'b0)
    wr(8'h28, 32'h00000001);
    `CHK(iq, 1'b1)
    wr(8'h24, 32'h00000001);
    `CHK(iq, 1'b0)
    rd(8'h20, 32'h0, 2'h0);
    $display("t_evt done");
  endtask

  // Bus-off and passive share one sequence; both are edge triggered
  task automatic lv(input logic [8:0] e, input logic [31:0] en);
    wr(8'h14, 32'h00018000);
    hw <= e;
    repeat (3) @(posedge clk);
    `CHK(irq[2], 1'b0)
    hw <= 9'h000;
    repeat (3) @(posedge clk);
    wr(8'h14, en);
    hw <= e;
    repeat (3) @(posedge clk);
    `CHK(irq[2], 1'b1)
    wr(8'h14, en & 32'hFFFF7FFF);
    `CHK(irq[2], 1'b0)
    wr(8'h18, 32'h00000001);
    hw <= 9'h000;
    repeat (2) @(posedge clk);
  endtask

  task t_int;
    pe(9'h080);
    `CHK(irq, 5'h00)
    rd(8'h18, 32'h00000002, 2'h0);
    wr(8'h14, 32'h00038000);
    `CHK(irq, 5'h10)
    pe(9'h040);
    `CHK(irq, 5'h18)
    pe(9'h02C);
    `CHK(irq, 5'h18)
    wr(8'h14, 32'h00038800);
    pe(9'h020);
    `CHK(irq, 5'h18)
    pe(9'h034);
    `CHK(irq, 5'h1C)
    wr(8'h18, 32'h00000007);
    `CHK(irq, 5'h00)
    lv(9'h002, 32'h00018400);
    lv(9'h001, 32'h00018200);
    $display("t_int done");
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_fifo();
    t_evt();
    t_int();
    summarize();
  end
endmodule // cfi_top_test
